//--- cfgcs_assertions.sv
`default_nettype none
module cfgcs_checker #(
   parameter int POR_STD_CYC  = 20,
   parameter int POR_FAST_CYC = 10,
   parameter int PULSE_MAX    = 5000
) (
   input wire logic       CLK_I,
   input wire logic       RST_I,
   input wire logic [2:0] SCHEME_SELECT_I,
   input wire logic       CONFIG_REQUEST_N_I,
   input wire logic       POR_SPEED_SELECT_I,
   input wire logic       CONFIG_STATUS_N_I,
   input wire logic       CONFIG_STATUS_N_OE_O,
   input wire logic       JTAG_MODE_I,
   input wire logic       CFG_ERROR_I,
   input wire logic       CFG_DONE_I,
   input wire logic [2:0] SCHEME_O,
   input wire logic       CFG_START_O,
   input wire logic       CFG_ACTIVE_O,
   input wire logic       USER_MODE_O,
   input wire logic       USER_IO_HIZ_O
);
   timeunit 1ns;
   timeprecision 1ns;
   int   cnt;
   logic por_done;
   wire  req_on = CONFIG_REQUEST_N_I | JTAG_MODE_I;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   // cycles of status held low while the request pin is high or JTAG mode is on
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cnt <= 0;
         por_done <= 1'b0;
      end else begin
         cnt <= (CONFIG_STATUS_N_OE_O && req_on) ? cnt + 1 : 0;
         if (!CONFIG_STATUS_N_OE_O) por_done <= 1'b1;
      end
   end
   a_hiz_user: assert property (USER_IO_HIZ_O != USER_MODE_O)
      else $error("user io float wrong");
   a_user_drop: assert property (
      USER_MODE_O && !req_on |=> !USER_MODE_O && USER_IO_HIZ_O)
      else $error("user mode kept on request");
   a_start_sel: assert property (
      CFG_START_O |-> SCHEME_O == $past(SCHEME_SELECT_I))
      else $error("scheme not captured");
   a_cfg_req: assert property (CFG_ACTIVE_O && !req_on |=> !CFG_ACTIVE_O)
      else $error("configured with request low");
   a_jtag_keep: assert property (CFG_ACTIVE_O && JTAG_MODE_I && !CFG_ERROR_I &&
      !CFG_DONE_I && CONFIG_STATUS_N_I |=> CFG_ACTIVE_O)
      else $error("jtag mode left configuration");
   a_ext_err: assert property (CFG_ACTIVE_O && req_on && !CONFIG_STATUS_N_I &&
      !CONFIG_STATUS_N_OE_O |-> ##[1:2] CONFIG_STATUS_N_OE_O)
      else $error("outside low not taken as error");
   a_err_drive: assert property (
      CFG_ACTIVE_O && req_on && CFG_ERROR_I |-> ##[1:2] CONFIG_STATUS_N_OE_O)
      else $error("error not driven on status");
   a_user_keep: assert property (
      USER_MODE_O && req_on |=> USER_MODE_O && !CONFIG_STATUS_N_OE_O)
      else $error("user mode disturbed");
   a_por_hold: assert property ($fell(CONFIG_STATUS_N_OE_O) && !por_done |->
      cnt >= (POR_SPEED_SELECT_I ? POR_FAST_CYC : POR_STD_CYC))
      else $error("status released early");
   a_pulse_max: assert property (
      $fell(CONFIG_STATUS_N_OE_O) && por_done |-> cnt <= PULSE_MAX)
      else $error("error pulse too long");
endmodule
`default_nettype wire

//--- cfgcs_defs.vh
`ifndef CFGCS_DEFS_VH
`define CFGCS_DEFS_VH

// clock rate
`define CFGCS_CLK_HZ          10000000

// power-on reset interval, least figures
`define CFGCS_POR_STD_MS      100
`define CFGCS_POR_FAST_MS     4
`define CFGCS_POR_STD_CYC     ((`CFGCS_POR_STD_MS * `CFGCS_CLK_HZ) / 1000)
`define CFGCS_POR_FAST_CYC    ((`CFGCS_POR_FAST_MS * `CFGCS_CLK_HZ) / 1000)

// auto-restart error pulse, 10 us least, 500 us most
`define CFGCS_PULSE_MIN_US    10
`define CFGCS_PULSE_MAX_US    500
`define CFGCS_PULSE_CYC       ((`CFGCS_PULSE_MIN_US * `CFGCS_CLK_HZ + 999999) / 1000000)
`define CFGCS_PULSE_MAX_CYC   (`CFGCS_PULSE_MAX_US * (`CFGCS_CLK_HZ / 1000000))

// register byte offsets
`define CFGCS_CTRL_OFS        4'h0
`define CFGCS_STATE_OFS       4'h4
`define CFGCS_INT_STAT_OFS    4'h8
`define CFGCS_INT_MASK_OFS    4'hC

// control register fields
`define CFGCS_CTRL_AUTO_BIT   0
`define CFGCS_CTRL_RST        1'h0

// interrupt bits
`define CFGCS_INT_W           5
`define CFGCS_INT_POR         0
`define CFGCS_INT_START       1
`define CFGCS_INT_ERROR       2
`define CFGCS_INT_USER        3
`define CFGCS_INT_EXT         4
`define CFGCS_INT_RST         5'h00

// state register fields
`define CFGCS_ST_STATE_LSB    0
`define CFGCS_ST_SCHEME_LSB   8
`define CFGCS_ST_REQ_BIT      12
`define CFGCS_ST_STATUS_BIT   13
`define CFGCS_ST_POR_SPEED_SELECT_BIT   14

// axi responses
`define CFGCS_RESP_OKAY       2'h0
`define CFGCS_RESP_SLVERR     2'h2

`endif

//--- cfgcs_host.sv
`default_nettype none
module cfgcs_host (
   input  wire logic clk_i,
   input  wire logic req_low_i,
   input  wire logic pull_i,
   input  wire logic dut_oe_i,
   output var  logic req_n_o = 1'b1,
   output wire logic status_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // request high to configure, low to reconfigure
   always @(posedge clk_i) req_n_o <= ~req_low_i;
   // wire has a pull-up, low while either side pulls
   assign status_n_o = ~(dut_oe_i | pull_i);
endmodule
`default_nettype wire

//--- cfgcs_timer.v
`default_nettype none

// down counter: loads a count, flags expiry when it reaches zero
module cfgcs_timer #(
   parameter W = 20
) (
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire         load_i,
   input  wire [W-1:0] load_val_i,
   output wire         expired_o
);

   reg [W-1:0] count;

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count <= {W{1'b0}};
      end else if (load_i) begin
         count <= load_val_i;
      end else if (count != {W{1'b0}}) begin
         count <= count - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign expired_o = (count == {W{1'b0}}) & ~load_i;

endmodule

`default_nettype wire

//--- cfgcs_top.v
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`include "cfgcs_defs.vh"
`default_nettype none

module cfgcs_top #(
   parameter POR_STD_CYC  = `CFGCS_POR_STD_CYC,
   parameter POR_FAST_CYC = `CFGCS_POR_FAST_CYC,
   parameter PULSE_CYC    = `CFGCS_PULSE_CYC,
   parameter TW           = 20
) (
   // clock and reset
   input  wire        CLK_I,
   input  wire        RST_I,
   // axi4-lite write channels
   input  wire [3:0]  S_AXI_AWADDR_I,
   input  wire        S_AXI_AWVALID_I,
   output reg         S_AXI_AWREADY_O,
   input  wire [31:0] S_AXI_WDATA_I,
   input  wire [3:0]  S_AXI_WSTRB_I,
   input  wire        S_AXI_WVALID_I,
   output reg         S_AXI_WREADY_O,
   output reg  [1:0]  S_AXI_BRESP_O,
   output reg         S_AXI_BVALID_O,
   input  wire        S_AXI_BREADY_I,
   // axi4-lite read channels
   input  wire [3:0]  S_AXI_ARADDR_I,
   input  wire        S_AXI_ARVALID_I,
   output reg         S_AXI_ARREADY_O,
   output reg  [31:0] S_AXI_RDATA_O,
   output reg  [1:0]  S_AXI_RRESP_O,
   output reg         S_AXI_RVALID_O,
   input  wire        S_AXI_RREADY_I,
   // configuration pins
   input  wire [2:0]  SCHEME_SELECT_I,
   input  wire        CONFIG_REQUEST_N_I,
   input  wire        POR_SPEED_SELECT_I,
   input  wire        CONFIG_STATUS_N_I,
   output reg         CONFIG_STATUS_N_O,
   output reg         CONFIG_STATUS_N_OE_O,
   // core side
   input  wire        JTAG_MODE_I,
   input  wire        CFG_ERROR_I,
   input  wire        CFG_DONE_I,
   output reg  [2:0]  SCHEME_O,
   output reg         CFG_START_O,
   output reg         CFG_ACTIVE_O,
   output reg         USER_MODE_O,
   output reg         USER_IO_HIZ_O,
   output reg         IRQ_O
);

   localparam [5:0] ST_POR   = 6'h01;
   localparam [5:0] ST_RESET = 6'h02;
   localparam [5:0] ST_CFG   = 6'h04;
   localparam [5:0] ST_PULSE = 6'h08;
   localparam [5:0] ST_HOLD  = 6'h10;
   localparam [5:0] ST_USER  = 6'h20;

   reg  [5:0]  state;
   reg  [5:0]  next_state;
   reg         first;
   reg         auto_restart;
   reg  [`CFGCS_INT_W-1:0] int_stat;
   reg  [`CFGCS_INT_W-1:0] int_mask;
   reg  [`CFGCS_INT_W-1:0] ev;
   wire [`CFGCS_INT_W-1:0] next_int;
   wire        expired;
   wire        ext_low;
   wire        req_low;
   wire        tmr_load;
   wire [TW-1:0] tmr_val;
   wire        wr_go;
   wire [31:0] st_word;
   reg  [31:0] rd_word;
   reg         rd_ok;

   // an outside low only counts while this end is not pulling the line
   assign ext_low = ~CONFIG_STATUS_N_I & ~CONFIG_STATUS_N_OE_O;
   assign req_low = ~CONFIG_REQUEST_N_I & ~JTAG_MODE_I;

   assign tmr_load = first | ((next_state == ST_PULSE) & (state != ST_PULSE));
   assign tmr_val  = first ? (POR_SPEED_SELECT_I ? POR_FAST_CYC[TW-1:0] : POR_STD_CYC[TW-1:0])
                           : PULSE_CYC[TW-1:0];

   cfgcs_timer #(
      .W (TW)
   ) u_timer (
      .clk_i      (CLK_I),
      .rst_i      (RST_I),
      .load_i     (tmr_load),
      .load_val_i (tmr_val),
      .expired_o  (expired)
   );

   always @* begin
      next_state = state;
      ev         = {`CFGCS_INT_W{1'b0}};
      case (state)
         ST_POR: begin
            if (!first && expired) begin
               ev[`CFGCS_INT_POR] = 1'b1;
               if (req_low) begin
                  next_state = ST_RESET;
               end else begin
                  next_state = ST_CFG;
                  ev[`CFGCS_INT_START] = 1'b1;
               end
            end
         end
         ST_RESET: begin
            if (!req_low) begin
               next_state = ST_CFG;
               ev[`CFGCS_INT_START] = 1'b1;
            end
         end
         ST_CFG: begin
            if (req_low) begin
               next_state = ST_RESET;
            end else if (CFG_ERROR_I || ext_low) begin
               ev[`CFGCS_INT_ERROR] = 1'b1;
               ev[`CFGCS_INT_EXT]   = ext_low;
               next_state = auto_restart ? ST_PULSE : ST_HOLD;
            end else if (CFG_DONE_I) begin
               next_state = ST_USER;
               ev[`CFGCS_INT_USER] = 1'b1;
            end
         end
         ST_PULSE: begin
            if (req_low) begin
               next_state = ST_RESET;
            end else if (expired) begin
               next_state = ST_CFG;
               ev[`CFGCS_INT_START] = 1'b1;
            end
         end
         ST_HOLD: begin
            if (req_low) begin
               next_state = ST_RESET;
            end
         end
         ST_USER: begin
            if (req_low) begin
               next_state = ST_RESET;
            end
         end
         default: begin
            next_state = ST_POR;
         end
      endcase
   end

   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state                <= ST_POR;
         first                <= 1'b1;
         SCHEME_O             <= 3'h0;
         CFG_START_O          <= 1'b0;
         CFG_ACTIVE_O         <= 1'b0;
         USER_MODE_O          <= 1'b0;
         USER_IO_HIZ_O        <= 1'b1;
         CONFIG_STATUS_N_O    <= 1'b0;
         CONFIG_STATUS_N_OE_O <= 1'b1;
      end else begin
         state       <= next_state;
         first       <= 1'b0;
         CFG_START_O <= ev[`CFGCS_INT_START];
         if (ev[`CFGCS_INT_START]) begin
            SCHEME_O <= SCHEME_SELECT_I;
         end
         CFG_ACTIVE_O  <= (next_state == ST_CFG);
         USER_MODE_O   <= (next_state == ST_USER);
         USER_IO_HIZ_O <= (next_state != ST_USER);
         CONFIG_STATUS_N_O <= 1'b0;
         CONFIG_STATUS_N_OE_O <= (next_state == ST_POR) | (next_state == ST_RESET) |
                                 (next_state == ST_PULSE) | (next_state == ST_HOLD);
      end
   end

   // axi4-lite slave
   assign wr_go = S_AXI_AWVALID_I & S_AXI_AWREADY_O & S_AXI_WVALID_I & S_AXI_WREADY_O;

   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         S_AXI_AWREADY_O <= 1'b0;
         S_AXI_WREADY_O  <= 1'b0;
         S_AXI_BVALID_O  <= 1'b0;
         S_AXI_BRESP_O   <= `CFGCS_RESP_OKAY;
         auto_restart    <= `CFGCS_CTRL_RST;
         int_mask        <= `CFGCS_INT_RST;
      end else begin
         S_AXI_AWREADY_O <= S_AXI_AWVALID_I & S_AXI_WVALID_I & ~S_AXI_AWREADY_O &
                            ~S_AXI_BVALID_O;
         S_AXI_WREADY_O  <= S_AXI_AWVALID_I & S_AXI_WVALID_I & ~S_AXI_AWREADY_O &
                            ~S_AXI_BVALID_O;
         if (wr_go) begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O  <= `CFGCS_RESP_OKAY;
            case (S_AXI_AWADDR_I)
               `CFGCS_CTRL_OFS: begin
                  if (S_AXI_WSTRB_I[0]) begin
                     auto_restart <= S_AXI_WDATA_I[`CFGCS_CTRL_AUTO_BIT];
                  end
               end
               `CFGCS_INT_MASK_OFS: begin
                  if (S_AXI_WSTRB_I[0]) begin
                     int_mask <= S_AXI_WDATA_I[`CFGCS_INT_W-1:0];
                  end
               end
               `CFGCS_INT_STAT_OFS, `CFGCS_STATE_OFS: begin
                  S_AXI_BRESP_O <= `CFGCS_RESP_OKAY;
               end
               default: begin
                  S_AXI_BRESP_O <= `CFGCS_RESP_SLVERR;
               end
            endcase
         end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
         end
      end
   end

   // sticky events, write one to clear, a new event wins over the clear
   genvar gi;
   generate
      for (gi = 0; gi < `CFGCS_INT_W; gi = gi + 1) begin : g_int
         assign next_int[gi] = ev[gi] | (int_stat[gi] &
                               ~(wr_go & (S_AXI_AWADDR_I == `CFGCS_INT_STAT_OFS) &
                                 S_AXI_WSTRB_I[0] & S_AXI_WDATA_I[gi]));
      end
   endgenerate

   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         int_stat <= `CFGCS_INT_RST;
         IRQ_O    <= 1'b0;
      end else begin
         int_stat <= next_int;
         IRQ_O    <= |(next_int & int_mask);
      end
   end

   assign st_word = {17'h00000, POR_SPEED_SELECT_I, CONFIG_STATUS_N_I, CONFIG_REQUEST_N_I,
                     1'b0, SCHEME_O, 2'h0, state};

   always @* begin
      rd_ok   = 1'b1;
      rd_word = 32'h00000000;
      case (S_AXI_ARADDR_I)
         `CFGCS_CTRL_OFS:     rd_word = {31'h00000000, auto_restart};
         `CFGCS_STATE_OFS:    rd_word = st_word;
         `CFGCS_INT_STAT_OFS: rd_word = {27'h0000000, int_stat};
         `CFGCS_INT_MASK_OFS: rd_word = {27'h0000000, int_mask};
         default:             rd_ok   = 1'b0;
      endcase
   end

   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         S_AXI_ARREADY_O <= 1'b0;
         S_AXI_RVALID_O  <= 1'b0;
         S_AXI_RDATA_O   <= 32'h00000000;
         S_AXI_RRESP_O   <= `CFGCS_RESP_OKAY;
      end else begin
         S_AXI_ARREADY_O <= S_AXI_ARVALID_I & ~S_AXI_ARREADY_O & ~S_AXI_RVALID_O;
         if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O  <= rd_word;
            S_AXI_RRESP_O  <= rd_ok ? `CFGCS_RESP_OKAY : `CFGCS_RESP_SLVERR;
         end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

//--- test_config_control_status_pins.sv
`default_nettype none
module test_config_control_status_pins;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic        psel = 0, jtag = 0, err = 0, done = 0, rq = 0, pull = 0;
   logic [2:0]  sel = 0;
   logic [3:0]  awa = 0, ara = 0, ws = 4'hF;
   logic [31:0] wd = 0, rd;
   logic [1:0]  rsp;
   wire         awr, wrr, bv, arr, rv, oe, start, act, user, hiz, irq, rqn, stn, sto;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [2:0]  sch;
   int          n_fail = 0, total_checks = 0, cyc = 0, n, lo;
   int          q[$];
   always #50 clk = ~clk;
   cfgcs_top #(.POR_STD_CYC(20), .POR_FAST_CYC(10), .PULSE_CYC(5)) u_dut (
      .CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
      .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv),
      .S_AXI_WREADY_O(wrr), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
      .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr),
      .SCHEME_SELECT_I(sel), .CONFIG_REQUEST_N_I(rqn), .POR_SPEED_SELECT_I(psel),
      .CONFIG_STATUS_N_I(stn), .CONFIG_STATUS_N_O(sto), .CONFIG_STATUS_N_OE_O(oe),
      .JTAG_MODE_I(jtag), .CFG_ERROR_I(err), .CFG_DONE_I(done), .SCHEME_O(sch),
      .CFG_START_O(start), .CFG_ACTIVE_O(act), .USER_MODE_O(user), .USER_IO_HIZ_O(hiz),
      .IRQ_O(irq));
   cfgcs_host u_host (.clk_i(clk), .req_low_i(rq), .pull_i(pull), .dut_oe_i(oe),
      .req_n_o(rqn), .status_n_o(stn));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      br <= 1;
      do @(posedge clk); while (!(awr && wrr));
      awv <= 0;
      wv <= 0;
      do @(posedge clk); while (!bv);
      br <= 0;
      rsp = bresp;
   endtask
   task automatic rdr(input logic [3:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1;
      rr <= 1;
      do @(posedge clk); while (!arr);
      arv <= 0;
      do @(posedge clk); while (!rv);
      rr <= 0;
      rd = rdata;
      rsp = rresp;
   endtask
   task automatic wstart;
      for (n = 0; n < 200 && start !== 1'b1; n++) @(posedge clk);
      chk(start, 1);
      chk(sch, q.pop_front());
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      void'($urandom(32'h23E7));
      psel = 1'($urandom_range(1));
      sel = 3'($urandom_range(7));
      q.push_back(sel);
      repeat (8) @(posedge clk);
      rst <= 0;
      wstart();
      chk(n >= (psel ? 10 : 20) && n <= (psel ? 14 : 24), 1);
      chk(act, 1);
      $display("power-on test done");
      jtag <= 1;
      rq <= 1;
      repeat (6) @(posedge clk);
      chk(act, 1);
      rq <= 0;
      repeat (2) @(posedge clk);
      jtag <= 0;
      pull <= 1;
      repeat (2) @(posedge clk);
      pull <= 0;
      repeat (20) @(posedge clk);
      chk({oe, act}, 2'h2);
      rq <= 1;
      repeat (3) @(posedge clk);
      chk({act, hiz}, 2'h1);
      rq <= 0;
      q.push_back(sel);
      wstart();
      $display("request and outside error test done");
      done <= 1;
      do @(posedge clk); while (!user);
      done <= 0;
      pull <= 1;
      repeat (4) @(posedge clk);
      chk({user, oe, hiz}, 3'h4);
      pull <= 0;
      sel <= 3'($urandom_range(7));
      rq <= 1;
      repeat (3) @(posedge clk);
      chk({user, hiz}, 2'h1);
      q.push_back(sel);
      rq <= 0;
      wstart();
      $display("user mode test done");
      wr(4'h0, 32'h1);
      chk(rsp, 2'h0);
      err <= 1;
      @(posedge clk);
      err <= 0;
      lo = 0;
      q.push_back(sel);
      do begin
         @(posedge clk);
         lo += oe;
      end while (start !== 1'b1 && lo < 100);
      chk(lo >= 5 && lo <= 8, 1);
      chk(sto, 0);
      wstart();
      $display("auto restart test done");
      rq <= 1;
      repeat (3) @(posedge clk);
      chk(act, 0);
      rq <= 0;
      q.push_back(sel);
      wstart();
      $display("request during configuration test done");
      rdr(4'h8);
      chk(rd, 32'h1F);
      chk(irq, 0);
      wr(4'hC, 32'h4);
      repeat (2) @(posedge clk);
      chk(irq, 1);
      wr(4'h8, 32'h4);
      repeat (2) @(posedge clk);
      chk(irq, 0);
      rdr(4'h8);
      chk(rd, 32'h1B);
      ws <= 4'h0;
      wr(4'hC, 32'h0);
      ws <= 4'hF;
      rdr(4'hC);
      chk(rd, 32'h4);
      wr(4'h4, 32'h0);
      chk(rsp, 2'h0);
      rdr(4'h4);
      chk({rd[14:12], rd[10:8], rd[5:0]}, {psel, 2'h3, sel, 6'h04});
      rdr(4'h2);
      chk(rsp, 2'h2);
      $display("register test done");
      psel <= ~psel;
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      q.push_back(sel);
      wstart();
      chk(n >= (psel ? 10 : 20) && n <= (psel ? 14 : 24), 1);
      chk(irq, 0);
      $display("second reset test done");
      conclude();
   end
endmodule
bind cfgcs_top cfgcs_checker #(.POR_STD_CYC(POR_STD_CYC), .POR_FAST_CYC(POR_FAST_CYC)) u_chk (
   .CLK_I(CLK_I), .RST_I(RST_I), .SCHEME_SELECT_I(SCHEME_SELECT_I),
   .CONFIG_REQUEST_N_I(CONFIG_REQUEST_N_I), .POR_SPEED_SELECT_I(POR_SPEED_SELECT_I),
   .CONFIG_STATUS_N_I(CONFIG_STATUS_N_I), .CONFIG_STATUS_N_OE_O(CONFIG_STATUS_N_OE_O),
   .JTAG_MODE_I(JTAG_MODE_I), .CFG_ERROR_I(CFG_ERROR_I), .CFG_DONE_I(CFG_DONE_I),
   .SCHEME_O(SCHEME_O), .CFG_START_O(CFG_START_O), .CFG_ACTIVE_O(CFG_ACTIVE_O),
   .USER_MODE_O(USER_MODE_O), .USER_IO_HIZ_O(USER_IO_HIZ_O));
`default_nettype wire
